// *** logic/msr_pkg.sv ***
// Package for the measurement sequencer and reading buffer.
// Assumes a 100 MHz core clock and an APB register bus of 32 bits.
package msr_pkg;

  // Clock and delay timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DLY_RES_NS    = 1000;
  localparam int unsigned CYC_PER_US    = DLY_RES_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  PRE_LOAD      = 7'(CYC_PER_US - 1);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CFG   = 8'h04;
  localparam logic [7:0] OFS_TRIG  = 8'h08;
  localparam logic [7:0] OFS_SAMP  = 8'h0c;
  localparam logic [7:0] OFS_DLY   = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Control, config and status fields
  localparam int unsigned CTRL_CMD_LSB = 0;
  localparam int unsigned CTRL_SRC_BIT = 3;
  localparam int unsigned CTRL_ABT_BIT = 4;
  localparam int unsigned CFG_RNG_LSB  = 4;
  localparam int unsigned STAT_CFG_BIT = 3;
  localparam int unsigned STAT_ERR_BIT = 4;
  localparam int unsigned STAT_CNT_LSB = 8;

  // Setting limits and reset values
  localparam logic [15:0] CNT_MIN = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hc350;
  localparam logic [31:0] DLY_MAX = 32'hd693a400;
  localparam int unsigned MEM_DEPTH = 512;

  // Reading word: sign, seven BCD digits, length flag, exponent
  localparam int unsigned RD_W     = 39;
  localparam int unsigned RD_NEG   = 38;
  localparam int unsigned RD_DMSB  = 37;
  localparam int unsigned RD_SEVEN = 9;
  localparam int unsigned RD_ENEG  = 8;

  // Characters
  localparam logic [7:0] ASC_0    = 8'h30;
  localparam logic [7:0] ASC_PLUS = 8'h2b;
  localparam logic [7:0] ASC_MIN  = 8'h2d;
  localparam logic [7:0] ASC_DOT  = 8'h2e;
  localparam logic [7:0] ASC_E    = 8'h45;
  localparam logic [7:0] ASC_LF   = 8'h0a;
  localparam logic [7:0] ASC_COMMA = 8'h2c;

  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_CONF  = 3'b001,
    CMD_MEAS  = 3'b010,
    CMD_READ  = 3'b011,
    CMD_INIT  = 3'b100,
    CMD_FETCH = 3'b101
  } msr_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_DELAY = 3'b010,
    ST_MEAS  = 3'b011,
    ST_STORE = 3'b100,
    ST_FETCH = 3'b101
  } msr_state_e;

endpackage

// *** logic/msr_fmt.sv ***
// Reading formatter: turns reading words into an ASCII byte stream.
// Assumes words arrive from a valid/ready source on the same clock.
`timescale 1ns/1ps
`default_nettype none
module msr_fmt (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [msr_pkg::RD_W-1:0]   in_word,
  input  wire logic                       in_last,
  output logic      [7:0]                 ob_data,
  output logic                            ob_valid,
  input  wire logic                       ob_ready,
  output logic                            ob_eoi
);
  logic [msr_pkg::RD_W-1:0] word_r;
  logic                     last_r;
  logic [3:0]               pos_r;
  logic [3:0]               pos_nxt;
  logic                     busy_r;
  logic [7:0]               data_r;
  logic                     eoi_r;
  logic                     adv;
  logic                     end_byte;
  logic                     load;

  // Character at one position of a reading
  function automatic logic [7:0] fmt_byte(input logic [38:0] w,
                                          input logic [3:0]  p);
    logic [3:0] k;
    k = (p == 4'h1) ? 4'h0 : 4'(p - 4'h2);
    case (p)
      4'h0: fmt_byte = w[msr_pkg::RD_NEG] ? msr_pkg::ASC_MIN
                                           : msr_pkg::ASC_PLUS;
      4'h2: fmt_byte = msr_pkg::ASC_DOT;
      4'h9: fmt_byte = msr_pkg::ASC_E;
      4'ha: fmt_byte = w[msr_pkg::RD_ENEG] ? msr_pkg::ASC_MIN
                                            : msr_pkg::ASC_PLUS;
      4'hb: fmt_byte = msr_pkg::ASC_0 | {4'h0, w[7:4]};
      4'hc: fmt_byte = msr_pkg::ASC_0 | {4'h0, w[3:0]};
      4'hd: fmt_byte = msr_pkg::ASC_LF;
      4'he: fmt_byte = msr_pkg::ASC_COMMA;
      default: fmt_byte = msr_pkg::ASC_0 |
                          {4'h0, w[msr_pkg::RD_DMSB - 4*k -: 4]};
    endcase
  endfunction

  // Six-digit readings skip the seventh digit; LF ends the last one
  assign pos_nxt  = (pos_r == 4'h7 && !word_r[msr_pkg::RD_SEVEN]) ?
                    4'h9 : 4'(pos_r + 4'h1);
  assign end_byte = (pos_r == 4'hd && last_r) || pos_r == 4'he;
  assign adv      = ce && busy_r && ob_ready;
  assign in_ready = ce && (!busy_r || (ob_ready && end_byte));
  assign load     = in_valid && in_ready;
  assign ob_valid = busy_r;
  assign ob_data  = data_r;
  assign ob_eoi   = eoi_r;

  // Byte sequencer; next byte is registered so data leaves a flop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word_r <= '0;
      last_r <= 1'b0;
      pos_r  <= 4'h0;
      busy_r <= 1'b0;
      data_r <= 8'h00;
      eoi_r  <= 1'b0;
    end else if (load) begin
      word_r <= in_word;
      last_r <= in_last;
      pos_r  <= 4'h0;
      busy_r <= 1'b1;
      data_r <= fmt_byte(in_word, 4'h0);
      eoi_r  <= 1'b0;
    end else if (adv) begin
      busy_r <= !end_byte;
      pos_r  <= pos_nxt;
      data_r <= fmt_byte(word_r, pos_nxt);
      eoi_r  <= !end_byte && last_r && pos_nxt == 4'hd;
    end
  end

  property p_eoi_lf;
    @(posedge core_clk) disable iff (!rstn)
      ob_valid && ob_eoi |-> ob_data == msr_pkg::ASC_LF && last_r;
  endproperty
  a_eoi_lf: assert property (p_eoi_lf)
    else $error("EOI shown on a byte other than the final LF");

  property p_comma;
    @(posedge core_clk) disable iff (!rstn)
      adv && ob_data == msr_pkg::ASC_LF && !last_r
      |=> ob_valid && ob_data == msr_pkg::ASC_COMMA && !ob_eoi;
  endproperty
  a_comma: assert property (p_comma)
    else $error("Comma missing between readings");
endmodule
`default_nettype wire

// *** logic/msr_seq.sv ***
// Measurement sequencer with reading memory and output buffer.
// Assumes an APB master on core_clk, a converter that answers
// meas_start with one meas_done pulse, and an async trigger pin.
//
// What this block does
// - Measure: configure, acquire, readings to output
// - Read uses stored setup; refused unconfigured
// - Trigger or sample count above one repeats
// - Full output buffer stalls, then resumes
// - Initiate stores readings in 512-word memory
// - Beyond 512 readings keep newest only
// - Fetch copies memory into output buffer
// - Reading as signed mantissa, E, exponent
// - LF after each reading, comma between
// - EOI only with final byte
// - External trigger starts burst on low pulse
// - Wait for trigger; count triggers, samples
// - Configure selects function, range; no start
// - Programmable delay before every measurement
// - Trigger count 1 to 50000
// - Sample count 1 to 50000
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module msr_seq #(
  parameter int unsigned OB_DEPTH = 16
) (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     ext_trig_n,
  output logic      [2:0]               func_sel,
  output logic      [3:0]               range_sel,
  output logic                          meas_start,
  input  wire logic                     meas_done,
  input  wire logic [msr_pkg::RD_W-1:0] meas_word,
  output logic      [7:0]               ob_data,
  output logic                          ob_valid,
  input  wire logic                     ob_ready,
  output logic                          ob_eoi
);
  localparam int unsigned OBW = $clog2(OB_DEPTH);
  localparam logic [9:0] MEM_FULL = 10'(msr_pkg::MEM_DEPTH);
  localparam logic [OBW:0] OB_FULL = (OBW+1)'(OB_DEPTH);

  // Register state
  logic [31:0] prdata_r;
  logic        src_ext_r;
  logic [7:0]  cfg_r;
  logic [15:0] trig_cnt_r;
  logic [15:0] samp_cnt_r;
  logic [31:0] dly_cfg_r;
  logic [2:0]  func_r;
  logic [3:0]  range_r;
  logic        configured_r;
  logic        err_r;

  // Sequencer state
  msr_pkg::msr_state_e st_r, st_nxt;
  logic        to_mem_r;
  logic [15:0] trig_left_r, trig_left_nxt;
  logic [15:0] samp_left_r, samp_left_nxt;
  logic [31:0] dly_r, dly_nxt;
  logic [6:0]  pre_r, pre_nxt;
  logic        start_nxt;
  logic        meas_start_r;
  logic [msr_pkg::RD_W-1:0] rd_word_r;

  // Reading memory and fetch walk
  logic [msr_pkg::RD_W-1:0] mem [msr_pkg::MEM_DEPTH];
  logic [8:0]  wr_ptr_r;
  logic [9:0]  fill_r;
  logic [8:0]  fetch_idx_r;
  logic [9:0]  fetch_left_r;

  // Output buffer
  logic [msr_pkg::RD_W:0] ob_mem [OB_DEPTH];
  logic [OBW-1:0] ob_wp_r, ob_rp_r;
  logic [OBW:0]   ob_cnt_r;

  // Trigger synchroniser
  logic trg_s1_r, trg_s2_r, trg_s3_r;

  // APB decode
  wire acc      = psel && penable && ce;
  wire wr_en    = acc && pwrite;
  wire rd_setup = psel && !penable && !pwrite && ce;
  wire hit_ctrl = paddr == msr_pkg::OFS_CTRL;
  wire hit_cfg  = paddr == msr_pkg::OFS_CFG;
  wire hit_trig = paddr == msr_pkg::OFS_TRIG;
  wire hit_samp = paddr == msr_pkg::OFS_SAMP;
  wire hit_dly  = paddr == msr_pkg::OFS_DLY;
  wire hit_stat = paddr == msr_pkg::OFS_STAT;
  wire mapped   = hit_ctrl | hit_cfg | hit_trig | hit_samp |
                  hit_dly | hit_stat;
  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_r;

  // Command decode; commands act only while idle
  wire wr_ctrl = wr_en && hit_ctrl;
  wire [2:0] cmd = pwdata[msr_pkg::CTRL_CMD_LSB +: 3];
  wire idle    = st_r == msr_pkg::ST_IDLE;
  wire abort   = wr_ctrl && pwdata[msr_pkg::CTRL_ABT_BIT];
  wire cmd_ok  = wr_ctrl && idle && !abort;
  wire go_conf = cmd_ok && cmd == msr_pkg::CMD_CONF;
  wire go_meas = cmd_ok && cmd == msr_pkg::CMD_MEAS;
  wire go_read = cmd_ok && cmd == msr_pkg::CMD_READ;
  wire go_init = cmd_ok && cmd == msr_pkg::CMD_INIT;
  wire go_fetch = cmd_ok && cmd == msr_pkg::CMD_FETCH;
  // Read and initiate need a prior configure
  wire needs_cfg = go_read || go_init;
  wire refused = needs_cfg && !configured_r;
  wire go_acq  = go_meas || (needs_cfg && configured_r);

  // Falling edge of the synchronised pin; stage one feeds stage two only
  wire ext_fall = trg_s3_r && !trg_s2_r;
  wire trig_hit = src_ext_r ? ext_fall : 1'b1;

  // Output buffer status drives the stall
  wire ob_full  = ob_cnt_r == OB_FULL;
  wire ob_empty = ob_cnt_r == '0;
  logic push;
  logic mem_we;
  logic fetch_step;
  logic fmt_ready;
  wire  pop = !ob_empty && fmt_ready;
  wire  last_acq = samp_left_r == 16'h1 && trig_left_r == 16'h1;
  wire [msr_pkg::RD_W-1:0] push_word =
    (st_r == msr_pkg::ST_FETCH) ? mem[fetch_idx_r] : rd_word_r;
  wire push_last = (st_r == msr_pkg::ST_FETCH) ?
                   fetch_left_r == 10'h1 : last_acq;

  // Count clamp into the legal range
  function automatic logic [15:0] clamp_cnt(input logic [31:0] v);
    if (v < 32'(msr_pkg::CNT_MIN))
      clamp_cnt = msr_pkg::CNT_MIN;
    else if (v > 32'(msr_pkg::CNT_MAX))
      clamp_cnt = msr_pkg::CNT_MAX;
    else
      clamp_cnt = v[15:0];
  endfunction

  // Register writes and APB read capture in the setup phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r   <= 32'h0;
      src_ext_r  <= 1'b0;
      cfg_r      <= 8'h00;
      trig_cnt_r <= msr_pkg::CNT_MIN;
      samp_cnt_r <= msr_pkg::CNT_MIN;
      dly_cfg_r  <= 32'h0;
    end else if (ce) begin
      if (rd_setup)
        prdata_r <= hit_ctrl ? {28'h0, src_ext_r, 3'h0} :
                    hit_cfg  ? {24'h0, cfg_r} :
                    hit_trig ? {16'h0, trig_cnt_r} :
                    hit_samp ? {16'h0, samp_cnt_r} :
                    hit_dly  ? dly_cfg_r :
                    hit_stat ? {14'h0, fill_r, 3'h0, err_r,
                                configured_r, st_r} : 32'h0;
      if (wr_ctrl && !abort)
        src_ext_r <= pwdata[msr_pkg::CTRL_SRC_BIT];
      if (wr_en && hit_cfg)
        cfg_r <= pwdata[7:0];
      if (wr_en && hit_trig)
        trig_cnt_r <= clamp_cnt(pwdata);
      if (wr_en && hit_samp)
        samp_cnt_r <= clamp_cnt(pwdata);
      if (wr_en && hit_dly) // Delay in microseconds, 1 us steps
        dly_cfg_r <= (pwdata > msr_pkg::DLY_MAX) ? msr_pkg::DLY_MAX
                                                 : pwdata;
    end
  end

  // Function selection; configure and measure latch it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      func_r       <= 3'h0;
      range_r      <= 4'h0;
      configured_r <= 1'b0;
      err_r        <= 1'b0;
    end else if (ce) begin
      if (go_conf || go_meas) begin
        func_r       <= cfg_r[2:0];
        range_r      <= cfg_r[msr_pkg::CFG_RNG_LSB +: 4];
        configured_r <= 1'b1;
      end
      if (cmd_ok)
        err_r <= refused;
    end
  end
  assign func_sel  = func_r;
  assign range_sel = range_r;

  // Sequencer next state
  always_comb begin
    st_nxt        = st_r;
    trig_left_nxt = trig_left_r;
    samp_left_nxt = samp_left_r;
    dly_nxt       = dly_r;
    pre_nxt       = pre_r;
    start_nxt     = 1'b0;
    push          = 1'b0;
    mem_we        = 1'b0;
    fetch_step    = 1'b0;
    case (st_r)
      msr_pkg::ST_IDLE: begin
        if (go_acq) begin
          trig_left_nxt = trig_cnt_r;
          st_nxt        = msr_pkg::ST_WAIT;
        end else if (go_fetch) begin
          st_nxt = msr_pkg::ST_FETCH;
        end
      end
      msr_pkg::ST_WAIT: begin
        if (trig_hit) begin
          samp_left_nxt = samp_cnt_r;
          dly_nxt       = dly_cfg_r;
          pre_nxt       = msr_pkg::PRE_LOAD;
          st_nxt        = msr_pkg::ST_DELAY;
        end
      end
      msr_pkg::ST_DELAY: begin
        // Microsecond prescaler keeps the delay counter 32 bits
        if (dly_r == 32'h0) begin
          start_nxt = 1'b1;
          st_nxt    = msr_pkg::ST_MEAS;
        end else if (pre_r == 7'h0) begin
          pre_nxt = msr_pkg::PRE_LOAD;
          dly_nxt = dly_r - 32'h1;
        end else begin
          pre_nxt = pre_r - 7'h1;
        end
      end
      msr_pkg::ST_MEAS: begin
        if (meas_done)
          st_nxt = msr_pkg::ST_STORE;
      end
      msr_pkg::ST_STORE: begin
        // Hold the reading while the output buffer is full
        if (to_mem_r || !ob_full) begin
          mem_we = to_mem_r;
          push   = !to_mem_r;
          if (samp_left_r != 16'h1) begin
            samp_left_nxt = samp_left_r - 16'h1;
            dly_nxt       = dly_cfg_r;
            pre_nxt       = msr_pkg::PRE_LOAD;
            st_nxt        = msr_pkg::ST_DELAY;
          end else if (trig_left_r != 16'h1) begin
            trig_left_nxt = trig_left_r - 16'h1;
            st_nxt        = msr_pkg::ST_WAIT;
          end else begin
            st_nxt = msr_pkg::ST_IDLE;
          end
        end
      end
      msr_pkg::ST_FETCH: begin
        if (fetch_left_r == 10'h0)
          st_nxt = msr_pkg::ST_IDLE;
        else if (!ob_full) begin
          push       = 1'b1;
          fetch_step = 1'b1;
        end
      end
      default: st_nxt = msr_pkg::ST_IDLE;
    endcase
    if (abort)
      st_nxt = msr_pkg::ST_IDLE;
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r         <= msr_pkg::ST_IDLE;
      trig_left_r  <= msr_pkg::CNT_MIN;
      samp_left_r  <= msr_pkg::CNT_MIN;
      dly_r        <= 32'h0;
      pre_r        <= 7'h0;
      meas_start_r <= 1'b0;
      to_mem_r     <= 1'b0;
      rd_word_r    <= '0;
    end else if (ce) begin
      st_r         <= st_nxt;
      trig_left_r  <= trig_left_nxt;
      samp_left_r  <= samp_left_nxt;
      dly_r        <= dly_nxt;
      pre_r        <= pre_nxt;
      meas_start_r <= start_nxt && !abort;
      if (go_acq)
        to_mem_r <= go_init;
      if (st_r == msr_pkg::ST_MEAS && meas_done)
        rd_word_r <= meas_word;
    end
  end
  assign meas_start = meas_start_r;

  // Circular reading memory; oldest entries are overwritten
  always_ff @(posedge core_clk) begin
    if (ce && mem_we)
      mem[wr_ptr_r] <= rd_word_r;
  end

  // Pointers; fetch starts at the oldest kept reading
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r     <= 9'h0;
      fill_r       <= 10'h0;
      fetch_idx_r  <= 9'h0;
      fetch_left_r <= 10'h0;
    end else if (ce) begin
      if (go_init && configured_r)
        fill_r <= 10'h0;
      else if (mem_we) begin
        wr_ptr_r <= wr_ptr_r + 9'h1;
        if (fill_r != MEM_FULL)
          fill_r <= fill_r + 10'h1;
      end
      if (go_fetch && !abort) begin
        fetch_idx_r  <= wr_ptr_r - fill_r[8:0];
        fetch_left_r <= fill_r;
      end else if (fetch_step) begin
        fetch_idx_r  <= fetch_idx_r + 9'h1;
        fetch_left_r <= fetch_left_r - 10'h1;
      end
    end
  end

  // Output buffer of whole readings with a last-reading mark
  always_ff @(posedge core_clk) begin
    if (ce && push)
      ob_mem[ob_wp_r] <= {push_last, push_word};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ob_wp_r  <= '0;
      ob_rp_r  <= '0;
      ob_cnt_r <= '0;
    end else if (ce) begin
      if (push)
        ob_wp_r <= (ob_wp_r == OBW'(OB_DEPTH - 1)) ? '0 : ob_wp_r + 1'b1;
      if (pop)
        ob_rp_r <= (ob_rp_r == OBW'(OB_DEPTH - 1)) ? '0 : ob_rp_r + 1'b1;
      if (push && !pop)
        ob_cnt_r <= ob_cnt_r + 1'b1;
      else if (pop && !push)
        ob_cnt_r <= ob_cnt_r - 1'b1;
    end
  end

  // Two flops before any logic reads the trigger pin
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trg_s1_r <= 1'b1;
      trg_s2_r <= 1'b1;
      trg_s3_r <= 1'b1;
    end else if (ce) begin
      trg_s1_r <= ext_trig_n;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
    end
  end

  // Serialiser for the host byte stream
  msr_fmt u_fmt (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .in_valid (!ob_empty),
    .in_ready (fmt_ready),
    .in_word  (ob_mem[ob_rp_r][msr_pkg::RD_W-1:0]),
    .in_last  (ob_mem[ob_rp_r][msr_pkg::RD_W]),
    .ob_data  (ob_data),
    .ob_valid (ob_valid),
    .ob_ready (ob_ready),
    .ob_eoi   (ob_eoi)
  );

  property p_conf_idle;
    @(posedge core_clk) disable iff (!rstn)
      go_conf |=> st_r == msr_pkg::ST_IDLE ##1 !meas_start;
  endproperty
  a_conf_idle: assert property (p_conf_idle)
    else $error("Configure started an acquisition");

  property p_stall;
    @(posedge core_clk) disable iff (!rstn)
      st_r == msr_pkg::ST_STORE && !to_mem_r && ob_full && !abort
      |-> !push ##1 st_r == msr_pkg::ST_STORE;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Sequencer moved on while output buffer full");

  property p_fill_sat;
    @(posedge core_clk) disable iff (!rstn)
      fill_r <= MEM_FULL;
  endproperty
  a_fill_sat: assert property (p_fill_sat)
    else $error("Memory fill count above capacity");

  property p_wrap;
    @(posedge core_clk) disable iff (!rstn)
      ce && mem_we && fill_r == MEM_FULL
      |=> fill_r == MEM_FULL && wr_ptr_r == $past(wr_ptr_r) + 9'h1;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Full memory did not overwrite the oldest reading");

  property p_start;
    @(posedge core_clk) disable iff (!rstn)
      $rose(st_r == msr_pkg::ST_MEAS) |-> meas_start ##1 !meas_start;
  endproperty
  a_start: assert property (p_start)
    else $error("Measurement start not a single pulse after delay");

  property p_wait;
    @(posedge core_clk) disable iff (!rstn)
      ce && st_r == msr_pkg::ST_WAIT && src_ext_r && !ext_fall && !abort
      |=> st_r == msr_pkg::ST_WAIT;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Left wait-for-trigger without a trigger");

  property p_refuse;
    @(posedge core_clk) disable iff (!rstn)
      refused |=> err_r && st_r == msr_pkg::ST_IDLE;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("Read accepted without configuration");

  property p_repeat;
    @(posedge core_clk) disable iff (!rstn)
      ce && push && st_r == msr_pkg::ST_STORE && !last_acq && !abort
      |=> st_r inside {msr_pkg::ST_DELAY, msr_pkg::ST_WAIT};
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("Acquisition ended before counts were used up");
endmodule
`default_nettype wire

// *** test/msr_conv.sv ***
// Converter model: answers each start with one done pulse and a word.
// Assumes it shares core_clk and rstn with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module msr_conv #(
  parameter int LAT = 3
) (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     meas_start,
  output logic                          meas_done,
  output logic [msr_pkg::RD_W-1:0]      meas_word
);
  int                       n;
  int                       cnt;
  logic [msr_pkg::RD_W-1:0] w;
  // Low digits carry the reading index, so a lost reading shows
  // Odd readings: negative, six digits, positive exponent
  assign w = {n[0], 16'h1234, 4'(n / 100 % 10), 4'(n / 10 % 10),
              4'(n % 10), !n[0], !n[0], 8'h03};
  // Inverted outside the pulse so a stale word is never mistaken
  assign meas_word = meas_done ? w : ~w;
  // One answer per start, a fixed latency later
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      n <= 0;
      meas_done <= 1'h0;
    end else begin
      meas_done <= (cnt == 1);
      if (meas_done) n <= n + 1;
      if (meas_start) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** test/msr_seq_tb.sv ***
// Bench for the sequencer: APB master, byte sink and trigger pin.
// Assumes the converter model numbers its readings from zero.
`timescale 1ns/1ps
`default_nettype none
module msr_seq_tb;
  logic        core_clk, rstn, psel, penable, pwrite, ext_trig_n, ob_ready;
  logic        pready, pslverr, meas_start, meas_done, ob_valid, ob_eoi, er;
  logic [7:0]  paddr, ob_data;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  func_sel;
  logic [3:0]  range_sel;
  logic [msr_pkg::RD_W-1:0] meas_word;
  int          err_total = 0, comparisons = 0, base = 0, starts = 0;
  // Small output buffer so that a stall is reached quickly
  msr_seq #(.OB_DEPTH(2)) dut (.core_clk, .rstn, .ce(1'h1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_trig_n, .func_sel, .range_sel, .meas_start, .meas_done,
    .meas_word, .ob_data, .ob_valid, .ob_ready, .ob_eoi);
  msr_conv conv (.core_clk, .rstn, .meas_start, .meas_done, .meas_word);
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (meas_start === 1'h1) starts++;
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    summarize();
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Idle cycle first, so back-to-back calls never reassign psel at once
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'h1 && t < 100);
    if (pready !== 1'h1) tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rs();
    apb(1'h0, msr_pkg::OFS_STAT, 32'h0);
  endtask
  task automatic go(int tr, int sa, logic [31:0] c);
    apb(1'h1, msr_pkg::OFS_TRIG, 32'(tr));
    apb(1'h1, msr_pkg::OFS_SAMP, 32'(sa));
    apb(1'h1, msr_pkg::OFS_CTRL, c);
  endtask
  task automatic wait_idle();
    int t;
    t = 0;
    do begin
      rs();
      t++;
    end while (rd[2:0] !== 3'h0 && t < 3000);
    if (t >= 3000) tmo();
  endtask
  // Drains cnt readings, expected index taken from base
  task automatic collect(int cnt);
    string s;
    int    t;
    int    i;
    ob_ready <= 1'h1;
    for (int r = 0; r < cnt; r++) begin
      i = (base + r) % 1000;
      // Odd readings come as six digits, negative, positive exponent
      s = i % 2 ? $sformatf("-1.234%02dE+03\n", i / 10)
                : $sformatf("+1.234%03dE-03\n", i);
      if (r != cnt - 1)
        s = {s, ","};
      for (int k = 0; k < s.len(); k++) begin
        t = 0;
        do begin
          @(posedge core_clk);
          t++;
        end while (ob_valid !== 1'h1 && t < 3000);
        if (ob_valid !== 1'h1) tmo();
        chk("ob_data", 32'(s[k]), 32'(ob_data));
        chk("ob_eoi", 32'(r == cnt - 1 && k == s.len() - 1),
            32'(ob_eoi));
      end
    end
    ob_ready <= 1'h0;
    base += cnt;
    wait_idle();
  endtask
  initial begin
    int n0;
    {psel, penable, pwrite, ob_ready, rstn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_trig_n = 1'h1;
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    apb(1'h1, msr_pkg::OFS_TRIG, 32'h0);
    apb(1'h0, msr_pkg::OFS_TRIG, 32'h0);
    chk("trig_cnt", 32'h1, rd);
    apb(1'h1, msr_pkg::OFS_SAMP, 32'hffff);
    apb(1'h0, msr_pkg::OFS_SAMP, 32'h0);
    chk("samp_cnt", 32'hc350, rd);
    apb(1'h0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, 32'(er));
    go(1, 1, 32'h3);
    rs();
    chk("read_refused", 32'h10, rd);
    $display("test registers done");
    apb(1'h1, msr_pkg::OFS_CFG, 32'h75);
    n0 = starts;
    go(1, 1, 32'h1);
    repeat (20) @(posedge core_clk);
    rs();
    chk("configured", 32'h8, rd);
    chk("func_sel", 32'h5, 32'(func_sel));
    chk("range_sel", 32'h7, 32'(range_sel));
    chk("no_start", 32'(n0), 32'(starts));
    go(2, 2, 32'h2);
    collect(4);
    $display("test configure and measure done");
    go(1, 6, 32'h2);
    repeat (300) @(posedge core_clk);
    rs();
    chk("stalled", 32'h1, 32'(rd[2:0] != 3'h0));
    collect(6);
    $display("test stall done");
    apb(1'h1, msr_pkg::OFS_DLY, 32'h1);
    go(1, 1, 32'hb);
    n0 = starts;
    repeat (40) @(posedge core_clk);
    chk("wait_trig", 32'(n0), 32'(starts));
    ext_trig_n <= 1'h0;
    n0 = 0;
    do begin
      @(posedge core_clk);
      n0++;
      if (n0 == 4) ext_trig_n <= 1'h1;
    end while (meas_start !== 1'h1 && n0 < 300);
    chk("delay", 32'h1, 32'(n0 >= 101 && n0 <= 112));
    collect(1);
    go(1, 1, 32'hb);
    apb(1'h1, msr_pkg::OFS_CTRL, 32'h10);
    rs();
    chk("abort", 32'h8, rd);
    apb(1'h1, msr_pkg::OFS_DLY, 32'h0);
    $display("test external trigger done");
    go(2, 3, 32'h4);
    wait_idle();
    chk("held", 32'h6, 32'(rd[17:8]));
    go(2, 3, 32'h5);
    collect(6);
    go(1, 515, 32'h4);
    wait_idle();
    chk("held_max", 32'd512, 32'(rd[17:8]));
    base += 3;
    go(1, 515, 32'h5);
    collect(512);
    $display("test memory done");
    summarize();
  end
endmodule
`default_nettype wire
